// File: rtl/gdp_defines.svh
// Constants of the general digital I/O port: offsets, fields, reset values, counts
// Behaviour
// [RQ1] Direction bit one makes the pin an output, zero an input.
// [RQ2] Input pin with drive value one gets a pull-up unless pull-ups are disabled.
// [RQ3] Output pin drives its drive value; no pull-up while output.
// [RQ4] Reset puts every pin in high impedance, even without clock. The reset here is synchronous and floats pins only on a clock edge.
// [RQ5] Writing one to an input-sample bit inverts the drive value bit.
// [RQ6] Global pull-up disable turns off pull-ups on every pin of every port.
// [RQ7] Per-port pull-up disable acts like the global one for its port only.
// [RQ8] Break-before-make: input-to-output change floats the pin for one cycle first.
// [RQ9] Break-before-make is chosen per port by its enable bit.
// [RQ10] Output-to-input change never inserts a float period.
// [RQ11] Software toggles a direction bit at most once per two cycles.
// [RQ12] Between states 0b00 and 0b11 software passes through 0b01 or 0b10.
// [RQ13] Between 0b01 and 0b10 software passes through 0b00 or 0b11.
// [RQ14] Pin level is readable through the input sample in every direction.
// [RQ15] Input path: falling-edge capture stage then rising-edge sample flop.
// [RQ16] A written drive value shows in the input sample one period later.
// [RQ17] Software inserts one idle instruction between a pin write and its read-back.
// [RQ18] Changing one pin's settings leaves all other pins of the port unchanged.
// [RQ19] Each port has output value, direction (read/write) and read-only input sample.
// [RQ20] Alternate use of some pins leaves the other pins working as plain I/O.
// [RQ21] Sleep clamps each digital input to ground unless overridden for that pin.
// [RQ22] After reset direction and output value are zero: inputs without pull-up.
`ifndef GDP_DEFINES_SVH
`define GDP_DEFINES_SVH

`define GDP_NPORTS 3
`define GDP_PW 8
`define GDP_PINS 24

// Per-port block at port_index * 0x10
`define GDP_OFF_SAMPLE 8'h00
`define GDP_OFF_DIR 8'h04
`define GDP_OFF_OUT 8'h08
`define GDP_OFF_MCUCTL 8'h40
`define GDP_OFF_PORTCTL 8'h44

`define GDP_MCU_PULLOFF_BIT 0
`define GDP_MCU_MASK 8'h01
`define GDP_PCR_BBM_LSB 0
`define GDP_PCR_PULLOFF_LSB 4
`define GDP_PCR_MASK 8'h77

`define GDP_RST_BYTE 8'h00
`define GDP_RST_WORD 32'h0000_0000

`endif

// File: rtl/gdp_pkg.sv
// Types shared by the general digital I/O port files
package gdp_pkg;
    typedef enum logic [2:0] {
        GDP_REG_NONE = 3'b000,
        GDP_REG_SAMPLE = 3'b001,
        GDP_REG_DIR = 3'b010,
        GDP_REG_OUT = 3'b011,
        GDP_REG_MCU = 3'b100,
        GDP_REG_PCR = 3'b101
    } gdp_reg_t;

    typedef enum logic [1:0] {
        GDP_OKAY = 2'b00,
        GDP_SLVERR = 2'b10
    } gdp_resp_t;

    typedef struct packed {
        gdp_reg_t kind;
        logic [1:0] port;
    } gdp_hit_t;
endpackage

// File: rtl/gdp_port.sv
// General digital I/O port block with AXI4-Lite register access
`timescale 1ns/1ns
`include "gdp_defines.svh"
module gdp_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [`GDP_PINS-1:0] pin_in,
    output logic [`GDP_PINS-1:0] pin_out,
    output logic [`GDP_PINS-1:0] pin_oe_n,
    output logic [`GDP_PINS-1:0] pin_pullup_en,
    input wire logic sleep_clamp,
    input wire logic [`GDP_PINS-1:0] clamp_override
);
    localparam int NP = `GDP_NPORTS;

    logic [NP-1:0][7:0] port_direction;
    logic [NP-1:0][7:0] port_output_value;
    logic [NP-1:0][7:0] port_input_sample;
    logic [7:0] mcu_control_register;
    logic [7:0] port_control_register;
    logic [NP-1:0][7:0] next_direction;
    logic [NP-1:0][7:0] next_output;
    logic [NP-1:0][7:0] next_oe_n;
    logic [NP-1:0][7:0] next_pull;
    logic [7:0] next_mcu;
    logic [7:0] next_pcr;
    logic [`GDP_PINS-1:0] gated_in;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_strb0;
    logic aw_full;
    logic w_full;
    logic do_write;
    logic next_aw_full;
    logic next_w_full;
    logic next_bvalid;
    logic next_rvalid;
    logic ar_take;
    gdp_pkg::gdp_hit_t wr_hit;
    gdp_pkg::gdp_hit_t rd_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Port blocks sit at 0x00, 0x10, 0x20; the two control words above them
    function automatic gdp_pkg::gdp_hit_t decode(input logic [7:0] addr);
        gdp_pkg::gdp_hit_t h;
        h.kind = gdp_pkg::GDP_REG_NONE;
        h.port = addr[5:4];
        if (addr[7:6] == 2'h0 && addr[5:4] < 2'(NP)) begin
            if (addr[3:2] == 2'(`GDP_OFF_SAMPLE >> 2)) begin
                h.kind = gdp_pkg::GDP_REG_SAMPLE;
            end else if (addr[3:2] == 2'(`GDP_OFF_DIR >> 2)) begin
                h.kind = gdp_pkg::GDP_REG_DIR;
            end else if (addr[3:2] == 2'(`GDP_OFF_OUT >> 2)) begin
                h.kind = gdp_pkg::GDP_REG_OUT;
            end
        end else if (addr[7:2] == 6'(`GDP_OFF_MCUCTL >> 2)) begin
            h.kind = gdp_pkg::GDP_REG_MCU;
        end else if (addr[7:2] == 6'(`GDP_OFF_PORTCTL >> 2)) begin
            h.kind = gdp_pkg::GDP_REG_PCR;
        end
        return h;
    endfunction

    assign wr_hit = decode(wr_addr);
    assign rd_hit = decode(araddr);

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    // Address and data are parked separately, so either may arrive first
    assign do_write = aw_full & w_full & ~bvalid;
    assign next_aw_full = (aw_full | (awvalid & awready)) & ~do_write;
    assign next_w_full = (w_full | (wvalid & wready)) & ~do_write;
    assign next_bvalid = do_write | (bvalid & ~bready);

    // Handshake flags; ready stays low while a response waits, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awready <= ~next_aw_full & ~next_bvalid;
            wready <= ~next_w_full & ~next_bvalid;
            bvalid <= next_bvalid;
        end
    end

    // Parked payload and the write answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_addr <= `GDP_RST_BYTE;
            wr_data <= `GDP_RST_BYTE;
            wr_strb0 <= 1'b0;
            bresp <= gdp_pkg::GDP_OKAY;
        end else begin
            if (awvalid && awready) begin
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wr_data <= wdata[7:0];
                wr_strb0 <= wstrb[0];
            end
            if (do_write) begin
                bresp <= (wr_hit.kind == gdp_pkg::GDP_REG_NONE) ? gdp_pkg::GDP_SLVERR
                                                                 : gdp_pkg::GDP_OKAY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign ar_take = arvalid & arready;
    assign next_rvalid = ar_take | (rvalid & ~rready);

    // One-cycle read answer; bits above the byte read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= `GDP_RST_WORD;
            rresp <= gdp_pkg::GDP_OKAY;
        end else begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (ar_take) begin
                rresp <= gdp_pkg::GDP_OKAY;
                case (rd_hit.kind)
                    gdp_pkg::GDP_REG_SAMPLE: begin
                        rdata <= {24'h0, port_input_sample[rd_hit.port]}; // RQ14
                    end
                    gdp_pkg::GDP_REG_DIR: begin
                        rdata <= {24'h0, port_direction[rd_hit.port]}; // RQ19
                    end
                    gdp_pkg::GDP_REG_OUT: begin
                        rdata <= {24'h0, port_output_value[rd_hit.port]}; // RQ19
                    end
                    gdp_pkg::GDP_REG_MCU: begin
                        rdata <= {24'h0, mcu_control_register};
                    end
                    gdp_pkg::GDP_REG_PCR: begin
                        rdata <= {24'h0, port_control_register};
                    end
                    default: begin
                        rdata <= `GDP_RST_WORD;
                        rresp <= gdp_pkg::GDP_SLVERR;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register next values

    // Byte-wide writes replace a direction or output word, sample writes toggle the output word; each pin bit is a flop of its own
    always_comb begin
        next_direction = port_direction;
        next_output = port_output_value;
        next_mcu = mcu_control_register;
        next_pcr = port_control_register;
        if (do_write && wr_strb0) begin
            case (wr_hit.kind)
                gdp_pkg::GDP_REG_SAMPLE: begin
                    next_output[wr_hit.port] = port_output_value[wr_hit.port] ^ wr_data; // RQ5
                end
                gdp_pkg::GDP_REG_DIR: begin
                    next_direction[wr_hit.port] = wr_data; // RQ18
                end
                gdp_pkg::GDP_REG_OUT: begin
                    next_output[wr_hit.port] = wr_data; // RQ18
                end
                gdp_pkg::GDP_REG_MCU: begin
                    next_mcu = wr_data & `GDP_MCU_MASK;
                end
                gdp_pkg::GDP_REG_PCR: begin
                    next_pcr = wr_data & `GDP_PCR_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Pin controls from next values so they line up with the register update
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            // Float only on a rising direction bit of a break-before-make port
            next_oe_n[p] = ~next_direction[p] // RQ1
                         | ({8{port_control_register[`GDP_PCR_BBM_LSB + p]}} // RQ9
                            & ~port_direction[p]); // RQ8 RQ10
            next_pull[p] = ~next_direction[p] & next_output[p] // RQ2 RQ3
                         & ~{8{next_mcu[`GDP_MCU_PULLOFF_BIT]}} // RQ6
                         & ~{8{next_pcr[`GDP_PCR_PULLOFF_LSB + p]}}; // RQ7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and pin drivers

    // Port words clear at reset: all pins inputs without pull-up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_direction <= '0; // RQ22
            port_output_value <= '0; // RQ22
            mcu_control_register <= `GDP_RST_BYTE;
            port_control_register <= `GDP_RST_BYTE;
        end else begin
            port_direction <= next_direction;
            port_output_value <= next_output;
            mcu_control_register <= next_mcu;
            port_control_register <= next_pcr;
        end
    end

    // Synchronous reset floats pins only on a clock edge; without clock they keep their last drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe_n <= '1; // RQ4
            pin_pullup_en <= '0; // RQ4
        end else begin
            pin_oe_n <= next_oe_n;
            pin_pullup_en <= next_pull;
        end
    end

    // Drive value goes straight from its register to the pad
    assign pin_out = port_output_value; // RQ3

    ////////////////////////////////////////////////////////////////////////////////
    // Input path

    // Clamp to ground in sleep ahead of the synchronizer, per-pin override
    assign gated_in = pin_in & ~({`GDP_PINS{sleep_clamp}} & ~clamp_override); // RQ21

    // Each port has its own synchronizer, so pins stay independent of neighbours
    genvar g;
    for (g = 0; g < NP; g++) begin : g_port
        gdp_sync u_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .din(gated_in[g*8 +: 8]), // RQ20
            .dout(port_input_sample[g]) // RQ15 RQ16
        );

        // Per-port pin behaviour checks
        input_float_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
            ((~port_direction[g] & ~pin_oe_n[g*8 +: 8]) == 8'h00))
            else $error("input pin is driven");
        steady_drive_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
            ((port_direction[g] & $past(port_direction[g]) & pin_oe_n[g*8 +: 8]) == 8'h00))
            else $error("steady output pin not driven");
        pull_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
            pin_pullup_en[g*8 +: 8] == (~port_direction[g] & port_output_value[g]
                & ~{8{mcu_control_register[`GDP_MCU_PULLOFF_BIT] // RQ6
                    | port_control_register[`GDP_PCR_PULLOFF_LSB + g]}})) // RQ7
            else $error("pull-up enable wrong");
        bbm_gap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
            $past(port_control_register[`GDP_PCR_BBM_LSB + g])
            |-> ((port_direction[g] & ~$past(port_direction[g])
                 & ~pin_oe_n[g*8 +: 8]) == 8'h00))
            else $error("no float cycle on turn to output");
        bbm_then_drive_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
            (port_direction[g] & ~$past(port_direction[g])) != 8'h00
            ##1 $stable(port_direction[g])
            |-> ((port_direction[g] & pin_oe_n[g*8 +: 8]) == 8'h00))
            else $error("pin not driven after float cycle");
        no_bbm_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
            !$past(port_control_register[`GDP_PCR_BBM_LSB + g])
            |-> ((port_direction[g] & pin_oe_n[g*8 +: 8]) == 8'h00))
            else $error("float cycle without break-before-make");
        fall_no_gap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
            ((~port_direction[g] & $past(port_direction[g]) & ~pin_oe_n[g*8 +: 8]) == 8'h00)
            && ((port_direction[g] & $past(port_direction[g]) & pin_oe_n[g*8 +: 8]) == 8'h00))
            else $error("glitch on turn to input");
        bbm_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
            port_control_register[`GDP_PCR_BBM_LSB + g] && !port_direction[g][0]
            ##1 port_direction[g][0] && pin_oe_n[g*8]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register and bus checks

    reset_float_a: assert property (@(posedge aclk) // RQ4
        !aresetn |=> (pin_oe_n == '1) && (pin_pullup_en == '0))
        else $error("pins not floated by reset");
    reset_clear_a: assert property (@(posedge aclk) // RQ22
        $rose(aresetn) |-> (port_direction == '0) && (port_output_value == '0))
        else $error("port words not cleared by reset");
    toggle_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
        do_write && wr_strb0 && wr_hit.kind == gdp_pkg::GDP_REG_SAMPLE
        |=> port_output_value[$past(wr_hit.port)]
            == ($past(port_output_value[wr_hit.port]) ^ $past(wr_data)))
        else $error("sample write did not toggle drive value");
    write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        aw_full && w_full && !bvalid |=> bvalid)
        else $error("write answer missing");
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take |=> rvalid && (rdata[31:8] == 24'h0))
        else $error("read answer missing");
    toggle_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        do_write && wr_hit.kind == gdp_pkg::GDP_REG_SAMPLE && wr_data != 8'h00);
    pullup_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        pin_pullup_en != '0 ##1 mcu_control_register[`GDP_MCU_PULLOFF_BIT]);
    read_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        rvalid && rready);
endmodule

// File: rtl/gdp_sync.sv
// Two-stage pin input synchronizer of one port
`timescale 1ns/1ns
`include "gdp_defines.svh"
module gdp_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] din,
    output logic [7:0] dout
);
    logic [7:0] capture;

    // Falling-edge stage stands in for the latch that closes when the clock falls
    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            capture <= `GDP_RST_BYTE;
        end else begin
            capture <= din; // RQ15
        end
    end

    // Rising-edge stage is the input-sample register itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout <= `GDP_RST_BYTE;
        end else begin
            dout <= capture; // RQ15
        end
    end
endmodule

// File: verif/gdp_pad_model.sv
// Pad model: resolves each pin level from the port, pull-ups and outside drivers
`timescale 1ns/1ns
module gdp_pad_model (
    input wire logic aclk,
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe_n,
    input wire logic [23:0] pin_pullup_en,
    input wire logic [23:0] ext_en,
    input wire logic [23:0] ext_val,
    output logic [23:0] pin_in
);
    logic [23:0] flip = 24'h000000;
    ////////////////////////////////////////////////////////////////////////////////
    // Floating pins flip every cycle, so a float never reads as a steady level
    always @(posedge aclk) begin
        flip <= ~flip;
    end
    // Port driver first, then outside driver, then pull-up
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pullup_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = flip[i];
            end
        end
    end
endmodule

// File: verif/testbench.sv
// Self-checking bench of the digital I/O port over its register bus and pads
`timescale 1ns/1ns
module testbench;
    logic aclk = 1'b0;
    logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sleep_clamp;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [23:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, clamp_override;
    logic [23:0] ext_en, ext_val, oe_snap;
    int n_mismatch = 0;
    int compares = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // 20 MHz clock
    always #25 aclk = ~aclk;
    gdp_port i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en), .sleep_clamp(sleep_clamp),
        .clamp_override(clamp_override));
    gdp_pad_model i_pads (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Write cycle; pin enables are caught in the cycle the response appears
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic s,
        input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= {24'h000000, v};
        wstrb <= {3'b000, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) begin
            n_mismatch++;
            stop_test();
        end
        oe_snap = pin_oe_n;
        chk(bresp, er);
        bready <= 1'b0;
        // One idle edge keeps drivers from assigning twice in one step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) begin
            n_mismatch++;
            stop_test();
        end
        d = rdata;
        chk(rresp, er);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] v);
        wr(a, v, 1'b1, 2'b00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset state, and unmapped places refused
    task automatic t_reset();
        chk(pin_oe_n, 32'h00ffffff);
        chk(pin_pullup_en, 32'h0);
        for (int p = 0; p < 3; p++) begin
            rd(8'(p * 16 + 4), 2'b00);
            chk(d, 32'h0);
            rd(8'(p * 16 + 8), 2'b00);
            chk(d, 32'h0);
        end
        rd(8'h0c, 2'b10);
        chk(d, 32'h0);
        wr(8'h30, 8'hff, 1'b1, 2'b10);
        wr(8'h08, 8'hff, 1'b0, 2'b00);
        rd(8'h08, 2'b00);
        chk(d, 32'h0);
    endtask
    // Mixed directions, then a single-bit change on port 0
    task automatic t_drive();
        w(8'h08, 8'hc3);
        w(8'h04, 8'h0f);
        chk(pin_oe_n[7:0], 8'hf0);
        chk(pin_pullup_en[7:0], 8'hc0);
        rd(8'h00, 2'b00);
        chk(d & 32'hcf, 32'hc3);
        w(8'h04, 8'h1f);
        chk(pin_oe_n, 32'h00ffffe0);
        chk(pin_pullup_en[7:0], 8'hc0);
    endtask
    // Ones written to the sample place toggle the drive value in any direction
    task automatic t_toggle();
        w(8'h00, 8'h81);
        rd(8'h08, 2'b00);
        chk(d, 32'h42);
        chk(pin_pullup_en[7:0], 8'h40);
        rd(8'h00, 2'b00);
        chk(d & 32'h5f, 32'h42);
    endtask
    // Pull-up disables, per port and global
    task automatic t_pull_off();
        w(8'h18, 8'hff);
        chk(pin_pullup_en[15:8], 8'hff);
        w(8'h44, 8'h20);
        chk(pin_pullup_en, 32'h00000040);
        w(8'h44, 8'h00);
        w(8'h40, 8'h01);
        chk(pin_pullup_en, 32'h0);
        rd(8'h40, 2'b00);
        chk(d, 32'h1);
        w(8'h40, 8'h00);
        chk(pin_pullup_en[15:8], 8'hff);
        w(8'h44, 8'hff);
        rd(8'h44, 2'b00);
        chk(d, 32'h77);
        chk(pin_pullup_en, 32'h0);
    endtask
    // Break-before-make on port 1 only; writes spaced well apart
    task automatic t_bbm();
        w(8'h44, 8'h02);
        w(8'h14, 8'h01);
        chk(oe_snap[8], 1'b1);
        chk(pin_oe_n[8], 1'b0);
        chk(pin_out[8], 1'b1);
        w(8'h04, 8'h3f);
        chk(oe_snap[5], 1'b0);
        w(8'h14, 8'h00);
        chk(oe_snap[8], 1'b1);
        w(8'h04, 8'h1f);
        chk(oe_snap[5], 1'b1);
    endtask
    // Outside drive on port 2, then the sleep clamp with some pins spared
    task automatic t_clamp();
        ext_en <= 24'hff0000;
        ext_val <= 24'ha50000;
        // Pad change needs a falling and a rising edge before the sample holds it
        repeat (2) @(posedge aclk);
        rd(8'h20, 2'b00);
        chk(d, 32'ha5);
        sleep_clamp <= 1'b1;
        clamp_override <= 24'h0f0000;
        repeat (2) @(posedge aclk);
        rd(8'h20, 2'b00);
        chk(d, 32'h05);
        sleep_clamp <= 1'b0;
        ext_en <= 24'h000000;
    endtask
    // Reset in mid-run floats every driven pin
    task automatic t_midreset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(pin_oe_n, 32'h00ffffff);
        chk(pin_out, 32'h0);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Bus must answer again right after release, with the words cleared
        rd(8'h04, 2'b00);
        chk(d, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        sleep_clamp = 1'b0;
        clamp_override = 24'h0;
        ext_en = 24'h0;
        ext_val = 24'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_drive();
        t_toggle();
        t_pull_off();
        t_bbm();
        t_clamp();
        t_midreset();
        stop_test();
    end
endmodule
